// ---- test/remote_uart.sv ----
// far-end serial sender driving the receive line
`timescale 1ns/10ps
`default_nettype none
module remote_uart (
	input wire sys_clk,
	input wire [7:0] tx_byte,
	input wire brk,
	input wire send,
	output logic rxd = 1'h1
);
	logic [11:0] sh;
	// even parity, one stop, then idle high; a break zeroes parity and stop too
	always @(send)
	begin
		sh = {1'h1, brk ? 11'h000 : {1'h1, ^tx_byte, tx_byte, 1'h0}};
		for (int i = 0; i < 192; i++)
			@(posedge sys_clk) rxd <= sh[i / 16];
	end
endmodule
`default_nettype wire

// ---- test/tb_uart_status.sv ----
// self-checking bench for the uart status block
`timescale 1ns/10ps
`default_nettype none
module tb_uart_status;
	logic sys_clk = 0, nrst = 0, read = 0, write = 0, cts_n = 1, brk = 0, send = 0;
	logic [23:0] address = 0;
	logic [7:0] writedata = 0, tx_byte = 0, m, e;
	logic [3:0] op, a;
	wire [7:0] readdata;
	wire waitrequest, rxd, txd;
	int n_mismatch = 0, comparisons = 0;
	// op 0 read, 1 write, 2 send, 3 set cts; op 2 and 3 then wait out a frame
	logic [23:0] rows [31] = '{24'h03FF00, 24'h300000, 24'h010100, 24'h2000A5, 24'h01FF86,
		24'h00FFA5, 24'h018000, 24'h210000, 24'h010808, 24'h000000, 24'h010800, 24'h200011,
		24'h200022, 24'h01A0A0, 24'h000000, 24'h012000, 24'h300001, 24'h120002, 24'h100055,
		24'h010400, 24'h300001, 24'h010200, 24'h300000, 24'h010606, 24'h120001, 24'h300001,
		24'h10003C, 24'h300001, 24'h018181, 24'h00FF3C, 24'h010100};
	uart_status dut_u (.*);
	remote_uart far_u (.*);
	initial forever #50 sys_clk = ~sys_clk;
	initial
	begin
		#1000000 n_mismatch++;
		summarize;
	end
	task summarize;
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task chk(input logic [7:0] s, e);
		comparisons++;
		if (s !== e)
		begin
			n_mismatch++;
			$display("[ERR] readdata exp %h got %h", e, s);
		end
	endtask
	task bus(input logic w, input logic [3:0] a, input logic [7:0] m, e);
		@(posedge sys_clk);
		{read, write, address, writedata} <= {!w, w, 20'hFFE20, a, e};
		@(posedge sys_clk);
		while (waitrequest !== 1'b0)
			@(posedge sys_clk);
		{read, write} <= 2'h0;
		if (!w)
			chk(readdata & m, e);
	endtask
	initial
	begin
		repeat (4) @(posedge sys_clk);
		nrst <= 1;
		foreach (rows[i])
		begin
			{op, a, m, e} = rows[i];
			if (op == 2)
				{brk, tx_byte, send} <= {a[0], e, !send};
			if (op == 3)
				cts_n <= e[0];
			if (op[1])
				repeat (200) @(posedge sys_clk);
			else
				bus(op[0], a, m, e);
		end
		nrst <= 0;
		repeat (4) @(posedge sys_clk);
		nrst <= 1;
		bus(0, 4'h1, 8'hFF, 8'h07);
		summarize;
	end
endmodule
`default_nettype wire

// ---- test/uart_status_monitor.sv ----
// port checks for the uart status block
`timescale 1ns/10ps
`default_nettype none
module uart_status_monitor (
	input wire sys_clk,
	input wire nrst,
	input wire [23:0] address,
	input wire read,
	input wire write,
	input wire [7:0] readdata,
	input wire waitrequest,
	input wire cts_n,
	input wire txd
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	sequence st_take;
		read && waitrequest && address == 24'hFFE201;
	endsequence
	a_reset_idle: assert property (disable iff (1'b0) !nrst |=> waitrequest && txd)
		else $error("reset");
	a_answer_next: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("no answer");
	a_answer_once: assert property (!waitrequest |=> waitrequest) else $error("long answer");
	a_idle_wait: assert property (!read && !write |=> waitrequest) else $error("stray answer");
	a_data_hold: assert property (!read |=> $stable(readdata)) else $error("readdata moved");
	a_unmapped_zero: assert property (read && address == 24'hFFE203 |=> readdata == 8'h00)
		else $error("unmapped read");
	a_cts_level: assert property (st_take |=>
		readdata[0] == $past(cts_n) || readdata[0] == readdata[7]) else $error("cts bit");
	a_idle_empty: assert property (st_take |=> !readdata[1] || readdata[2])
		else $error("idle not empty");
endmodule
bind uart_status uart_status_monitor mon_u (.*);
`default_nettype wire

// ---- verilog/uart_status.v ----
// uart channel with status flag register on an avalon-mm slave
//
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "uart_status_consts.vh"

// Summary of operation
// - all-zero character sets break detect flag
// - receive data read clears break flag
// - holding empty high when transmit register free
// - transmit data write clears holding empty
// - status bit 0 shows live clear-to-send
// - loopback substitutes receive-available for clear-to-send
// - clear-to-send gates start only when enabled
// - overrun errors held until data read
module uart_status (
	input wire sys_clk,
	input wire nrst,
	input wire [23:0] address,
	input wire read,
	input wire write,
	input wire [7:0] writedata,
	output reg [7:0] readdata,
	output reg waitrequest,
	input wire rxd,
	input wire cts_n,
	output reg txd
);
	// bus side
	reg ack_r;
	reg [7:0] readdata_nxt;
	reg [1:0] ctrl_r;

	// receiver state and flags
	reg [7:0] rx_data_r;
	reg [7:0] rx_data_nxt;
	reg rda_r;
	reg rda_nxt;
	reg pe_r;
	reg pe_nxt;
	reg oe_r;
	reg oe_nxt;
	reg fe_r;
	reg fe_nxt;
	reg brk_r;
	reg brk_nxt;
	reg [3:0] rx_div_r;
	reg [3:0] rx_div_nxt;
	reg [3:0] rx_bit_r;
	reg [3:0] rx_bit_nxt;
	reg [9:0] rx_sh_r;
	reg [9:0] rx_sh_nxt;
	reg rx_busy_r;
	reg rx_busy_nxt;

	// transmitter: start, 8 data, even parity, stop
	reg [7:0] thr_r;
	reg [7:0] thr_nxt;
	reg thr_empty_r;
	reg thr_empty_nxt;
	reg [10:0] tx_sh_r;
	reg [10:0] tx_sh_nxt;
	reg [3:0] tx_cnt_r;
	reg [3:0] tx_cnt_nxt;
	reg [3:0] tx_div_r;
	reg [3:0] tx_div_nxt;
	reg tx_busy_r;
	reg tx_busy_nxt;
	reg txd_nxt;

	// status image, built bit by bit
	reg [7:0] status;

	wire acc = (read | write) & ~ack_r;
	wire hit_data = address == `OFF_DATA;
	wire hit_stat = address == `OFF_STATUS;
	wire hit_ctrl = address == `OFF_CTRL;
	wire rd_data = acc & read & hit_data;
	wire wr_data = acc & write & hit_data;
	wire lb = ctrl_r[`CTRL_LOOPBACK_ENABLE];
	wire rx_in = lb ? txd : rxd;
	// loopback flow control uses the receiver's own availability
	wire cts_lvl = lb ? rda_r : cts_n;
	wire cts_ok = ~ctrl_r[`CTRL_CLEAR_TO_SEND_ENABLE] | ~cts_lvl;
	wire tx_idle = ~tx_busy_r & thr_empty_r;
	wire tx_start = ~tx_busy_r & ~thr_empty_r & cts_ok;
	wire rx_tick = rx_div_r == `DIV16;
	// stop is sampled after start, 8 data and parity are shifted in
	wire rx_done = rx_busy_r && rx_tick && rx_bit_r == `RX_STOP_IDX;
	wire rx_stop = rx_in;
	wire rx_par_bad = ^rx_sh_r[9:1];
	wire rx_break = (rx_sh_r[9:1] == 9'h000) & ~rx_stop;

	always @*
	begin
		status = 8'h00;
		status[`BIT_RDA] = rda_r;
		status[`BIT_PE] = pe_r;
		status[`BIT_OE] = oe_r;
		status[`BIT_FE] = fe_r;
		status[`BIT_BREAK_DETECT_FLAG] = brk_r;
		status[`BIT_TX_HOLDING_EMPTY_FLAG] = thr_empty_r;
		status[`BIT_TXE] = tx_idle;
		status[`BIT_CTS] = cts_lvl;
	end

	// unmapped addresses read as zero
	always @*
	begin
		readdata_nxt = readdata;
		if (acc & read)
		begin
			if (hit_data)
				readdata_nxt = rx_data_r;
			else if (hit_stat)
				readdata_nxt = status;
			else if (hit_ctrl)
				readdata_nxt = {6'h00, ctrl_r};
			else
				readdata_nxt = `UNMAPPED_RD;
		end
	end

	// one wait cycle, answer on second edge
	always @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			ack_r <= 1'b0;
			waitrequest <= 1'b1;
			readdata <= 8'h00;
		end
		else
		begin
			ack_r <= acc;
			waitrequest <= ~acc;
			readdata <= readdata_nxt;
		end
	end

	always @(posedge sys_clk)
	begin
		if (!nrst)
			ctrl_r <= `CTRL_RST;
		else if (acc & write & hit_ctrl)
			ctrl_r <= writedata[1:0];
	end

	// receiver and its flags; a new character wins over a same-cycle read
	always @*
	begin
		rx_busy_nxt = rx_busy_r;
		rx_div_nxt = rx_div_r;
		rx_bit_nxt = rx_bit_r;
		rx_sh_nxt = rx_sh_r;
		rx_data_nxt = rx_data_r;
		rda_nxt = rda_r;
		pe_nxt = pe_r;
		oe_nxt = oe_r;
		fe_nxt = fe_r;
		brk_nxt = brk_r;

		if (rd_data)
		begin
			rda_nxt = 1'b0;
			pe_nxt = 1'b0;
			oe_nxt = 1'b0;
			fe_nxt = 1'b0;
			brk_nxt = 1'b0;
		end

		if (!rx_busy_r)
		begin
			// first sample lands in the middle of the start bit
			rx_div_nxt = `RX_HALF;
			rx_bit_nxt = `CNT_RST;
			if (!rx_in)
				rx_busy_nxt = 1'b1;
		end
		else
		begin
			rx_div_nxt = rx_div_r + 4'h1;
			if (rx_tick)
			begin
				if (rx_bit_r == `CNT_RST && rx_in)
					rx_busy_nxt = 1'b0;
				else if (rx_done)
				begin
					rx_busy_nxt = 1'b0;
					// old byte stays, overrun flagged until next read
					if (rda_r & ~rd_data)
						oe_nxt = 1'b1;
					else
						rx_data_nxt = rx_sh_r[8:1];
					rda_nxt = 1'b1;
					pe_nxt = rx_par_bad;
					fe_nxt = ~rx_stop;
					brk_nxt = rx_break;
				end
				else
				begin
					rx_sh_nxt = {rx_in, rx_sh_r[9:1]};
					rx_bit_nxt = rx_bit_r + 4'h1;
				end
			end
		end
	end

	always @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			rx_busy_r <= 1'b0;
			rx_div_r <= `CNT_RST;
			rx_bit_r <= `CNT_RST;
			rx_sh_r <= 10'h000;
			rx_data_r <= 8'h00;
			rda_r <= 1'b0;
			pe_r <= 1'b0;
			oe_r <= 1'b0;
			fe_r <= 1'b0;
			brk_r <= 1'b0;
		end
		else
		begin
			rx_busy_r <= rx_busy_nxt;
			rx_div_r <= rx_div_nxt;
			rx_bit_r <= rx_bit_nxt;
			rx_sh_r <= rx_sh_nxt;
			rx_data_r <= rx_data_nxt;
			rda_r <= rda_nxt;
			pe_r <= pe_nxt;
			oe_r <= oe_nxt;
			fe_r <= fe_nxt;
			brk_r <= brk_nxt;
		end
	end

	// transmitter: holding register feeds the shifter
	always @*
	begin
		thr_nxt = thr_r;
		thr_empty_nxt = thr_empty_r;
		tx_busy_nxt = tx_busy_r;
		tx_sh_nxt = tx_sh_r;
		tx_cnt_nxt = tx_cnt_r;
		tx_div_nxt = tx_div_r;
		txd_nxt = txd;

		if (wr_data)
		begin
			thr_nxt = writedata;
			thr_empty_nxt = 1'b0;
		end

		if (!tx_busy_r)
		begin
			txd_nxt = 1'b1;
			if (tx_start)
			begin
				tx_sh_nxt = {1'b1, ^thr_r, thr_r, 1'b0};
				tx_busy_nxt = 1'b1;
				tx_cnt_nxt = `CNT_RST;
				tx_div_nxt = `CNT_RST;
				// write in the same cycle keeps the flag low
				if (!wr_data)
					thr_empty_nxt = 1'b1;
			end
		end
		else
		begin
			txd_nxt = tx_sh_r[0];
			tx_div_nxt = tx_div_r + 4'h1;
			if (tx_div_r == `DIV16)
			begin
				tx_sh_nxt = {1'b1, tx_sh_r[10:1]};
				tx_cnt_nxt = tx_cnt_r + 4'h1;
				if (tx_cnt_r == `TX_LAST_IDX)
					tx_busy_nxt = 1'b0;
			end
		end
	end

	always @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			thr_r <= 8'h00;
			thr_empty_r <= 1'b1;
			tx_busy_r <= 1'b0;
			tx_sh_r <= `TX_SH_IDLE;
			tx_cnt_r <= `CNT_RST;
			tx_div_r <= `CNT_RST;
			txd <= 1'b1;
		end
		else
		begin
			thr_r <= thr_nxt;
			thr_empty_r <= thr_empty_nxt;
			tx_busy_r <= tx_busy_nxt;
			tx_sh_r <= tx_sh_nxt;
			tx_cnt_r <= tx_cnt_nxt;
			tx_div_r <= tx_div_nxt;
			txd <= txd_nxt;
		end
	end
endmodule
`default_nettype wire

// ---- verilog/uart_status_consts.vh ----
// constants for the uart channel status block
`ifndef UART_STATUS_CONSTS_VH
`define UART_STATUS_CONSTS_VH
`define ADDR_W 24
`define OFF_DATA 24'hFFE200
`define OFF_STATUS 24'hFFE201
`define OFF_CTRL 24'hFFE202
`define BIT_RDA 7
`define BIT_PE 6
`define BIT_OE 5
`define BIT_FE 4
`define BIT_BREAK_DETECT_FLAG 3
`define BIT_TX_HOLDING_EMPTY_FLAG 2
`define BIT_TXE 1
`define BIT_CTS 0
`define CTRL_LOOPBACK_ENABLE 0
`define CTRL_CLEAR_TO_SEND_ENABLE 1
`define CTRL_RST 2'h0
`define UNMAPPED_RD 8'h00
`define DIV16 4'hF
`define RX_HALF 4'h8
`define RX_STOP_IDX 4'hA
`define TX_LAST_IDX 4'hA
`define CNT_RST 4'h0
`define TX_SH_IDLE 11'h7FF
`endif
